/* File: rtl/rmu_top.sv */
`timescale 1ns/1ps
`include "rmu_map.svh"
// Contract
// RQ1: Opcode 23 in bits 0-5 selects rotate-mask
// RQ2: Fields: source, dest, amount, begin, end, record
// RQ3: Rotate left by amount register bits 27-31
// RQ4: AND rotated word with generated mask
// RQ5: Begin below end+1: ones begin..end
// RQ6: Begin equals end+1: all ones
// RQ7: Begin above end+1: zeros end+1..begin-1
// RQ8: Record flag updates condition field zero
// RQ9: Rotate-mask never alters exception register
// RQ10: Opcode 31, extended 537 selects insert-bit
// RQ11: Source bit 0 rotated right, inserted
// RQ12: Insert-bit record flag updates condition field
// RQ13: Insert-bit never alters exception register
// RQ14: Other destination bits kept unchanged
// RQ15: Bit 0 is the most significant bit
// RQ16: Signed compare with zero, copy overflow
module rmu_top (
	input wire logic sys_clk_i, // Core clock
	input wire logic reset_n_i, // Async reset, active low
	input wire logic issue_i, // Instruction valid pulse
	input wire logic [31:0] instr_i, // Instruction word
	input wire logic [31:0] source_data_i, // Source register value
	input wire logic [31:0] amount_data_i, // Amount register value
	input wire logic [31:0] dest_data_i, // Old destination value
	input wire logic summary_ovf_i, // Current summary overflow
	input wire logic [31:0] xer_i, // Exception register value
	output logic [4:0] source_reg_field_o, // Source register index
	output logic [4:0] amount_reg_field_o, // Amount register index
	output logic wr_en_o, // Destination write pulse
	output logic [4:0] dest_reg_field_o, // Destination index
	output logic [31:0] wr_data_o, // Destination data
	output logic cr_wr_o, // Condition field write pulse
	output logic [3:0] condition_field_o, // neg,pos,zero,ovf
	output logic xer_wr_o, // Exception register write
	output logic [31:0] xer_o, // Exception register data
	output logic illegal_o // Unknown instruction pulse
);
	// Field decode, msb-first numbering maps bit n to 31-n
	logic [5:0] opcode; // Primary opcode
	logic [9:0] ext_opcode; // Extended opcode
	logic [4:0] mask_begin; // Mask begin field
	logic [4:0] mask_end; // Mask end field
	logic record_flag; // Record form
	logic [4:0] rot_count; // Rotate count
	rmu_pkg::rmu_op_type op; // Decoded operation
	logic [31:0] rotated; // Rotated source
	logic [31:0] mask; // Generated mask
	logic [31:0] result_nxt; // Result to write
	logic [3:0] cr_nxt; // Condition field value
	logic [31:0] rot_ref; // Reference rotation, read by checks only

	// All checks sample the core clock and sleep during reset
	default clocking cb_core @(posedge sys_clk_i); endclocking
	default disable iff (!reset_n_i);

	// Decode helper shared by write, record and refuse paths
	function automatic logic op_known(input rmu_pkg::rmu_op_type o);
		return o != rmu_pkg::RMU_OP_NONE;
	endfunction

	// Condition field of a result: neg, pos, zero, overflow copy
	function automatic logic [3:0] cond_of(input logic [31:0] w,
		input logic so);
		return {w[31], ~w[31] && (|w), ~(|w), so};
	endfunction

	// Issue of each kind, as seen on the sampling edge
	sequence s_issue_mask;
		issue_i && op == rmu_pkg::RMU_OP_ROTMASK;
	endsequence
	sequence s_issue_ins;
		issue_i && op == rmu_pkg::RMU_OP_INSBIT;
	endsequence
	sequence s_issue_bad;
		issue_i && op == rmu_pkg::RMU_OP_NONE;
	endsequence
	// Known operation with and without the record flag
	sequence s_issue_rec;
		issue_i && op_known(op) && record_flag;
	endsequence
	sequence s_issue_norec;
		issue_i && op_known(op) && !record_flag;
	endsequence
	// A cycle with nothing issued
	sequence s_idle;
		!issue_i;
	endsequence

	// Decoded registers are combinational on the same-cycle port
	always_comb begin
		opcode = instr_i[31:26]; // RQ1 RQ15
		ext_opcode = instr_i[10:1]; // RQ10
		mask_begin = instr_i[10:6]; // RQ2
		mask_end = instr_i[5:1]; // RQ2
		record_flag = instr_i[0]; // RQ2
		rot_count = amount_data_i[4:0]; // RQ3
		// Reference rotation for the checks, independent of the rotator
		rot_ref = (source_data_i << amount_data_i[4:0])
			| (source_data_i >> (6'h20 - {1'b0, amount_data_i[4:0]}));
	end

	// Operation select
	always_comb begin
		if (opcode == `RMU_OPC_ROTMASK) begin
			op = rmu_pkg::RMU_OP_ROTMASK; // RQ1
		end else if (opcode == `RMU_OPC_EXT && ext_opcode == `RMU_XO_INSBIT) begin
			op = rmu_pkg::RMU_OP_INSBIT; // RQ10
		end else begin
			op = rmu_pkg::RMU_OP_NONE;
		end
	end

	rmu_rotator u_rot (
		.data_i(source_data_i),
		.count_i(rot_count),
		.data_o(rotated)
	);

	rmu_mask_gen u_mask (
		.mask_begin_i(mask_begin),
		.mask_end_i(mask_end),
		.mask_o(mask)
	);

	// Result and condition computation
	always_comb begin
		case (op)
			rmu_pkg::RMU_OP_ROTMASK: begin
				result_nxt = rotated & mask; // RQ4
			end
			rmu_pkg::RMU_OP_INSBIT: begin
				// Msb position n lands at word bit 31-n; others kept
				result_nxt = dest_data_i; // RQ14
				result_nxt[5'h1f - rot_count] = source_data_i[31]; // RQ11
			end
			default: begin
				result_nxt = dest_data_i;
			end
		endcase
		cr_nxt = cond_of(result_nxt, summary_ovf_i); // RQ16
	end

	// Source, amount and destination index outputs register the fields for the next stage
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			source_reg_field_o <= 5'h00;
			amount_reg_field_o <= 5'h00;
			dest_reg_field_o <= 5'h00;
		end else if (issue_i) begin
			source_reg_field_o <= instr_i[25:21]; // RQ2
			dest_reg_field_o <= instr_i[20:16]; // RQ2
			amount_reg_field_o <= instr_i[15:11]; // RQ2
		end
	end

	// Destination write
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			wr_en_o <= 1'b0;
			wr_data_o <= 32'h0000_0000;
			illegal_o <= 1'b0;
		end else begin
			wr_en_o <= issue_i && op_known(op); // RQ1 RQ10
			illegal_o <= issue_i && !op_known(op); // RQ10
			if (issue_i) begin
				wr_data_o <= result_nxt;
			end
		end
	end

	// Condition field zero, only in record form
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cr_wr_o <= 1'b0;
			condition_field_o <= 4'h0;
		end else begin
			cr_wr_o <= issue_i && op_known(op) && record_flag; // RQ8 RQ12
			// Refused words leave the field alone as well
			if (issue_i && op_known(op) && record_flag) begin
				condition_field_o <= cr_nxt; // RQ16
			end
		end
	end

	// Exception register is never written by these operations
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			xer_wr_o <= 1'b0;
			xer_o <= 32'h0000_0000;
		end else begin
			xer_wr_o <= 1'b0; // RQ9 RQ13
			xer_o <= xer_i; // Echo unchanged value
		end
	end

	// Checks: each guards one step of a rule, tag on the label line
	// Expected rotations are rebuilt from the operands; the mask checks reuse the generated mask

	// A rotate-mask issue always writes its destination
	// Missing this pulse would silently drop a result
	a_write_pulse: assert property (s_issue_mask |=> wr_en_o) // RQ1
		else $error("rotate-mask not written");

	// Written word is the reference rotation under the mask
	// The reference rotation bypasses the rotator on purpose
	a_mask_and: assert property (s_issue_mask |=> // RQ4
		wr_data_o == $past(rot_ref & mask))
		else $error("masked result wrong");

	// Destination bits outside the mask always come out zero
	// Catches a mask that leaks rotated bits through
	a_mask_zero: assert property (s_issue_mask |=> // RQ4
		(wr_data_o & ~$past(mask)) == 32'h0000_0000)
		else $error("bits outside the mask set");

	// Begin just past end opens the whole word
	// Sizes widened by one bit so end 31 cannot wrap to zero
	a_full_mask: assert property ( // RQ6
		{1'b0, mask_begin} == {1'b0, mask_end} + 6'h01
		|-> mask == 32'hffff_ffff)
		else $error("full mask wrong");

	// Plain range: ones from begin through end, msb-first
	// Two opposite shifts bound the run from both sides
	a_mask_range: assert property ( // RQ5 RQ15
		mask_begin <= mask_end
		|-> mask == ((32'hffff_ffff >> mask_begin)
		& (32'hffff_ffff << (5'h1f - mask_end))))
		else $error("range mask wrong");

	// Split range: zeros from end+1 through begin-1, ones elsewhere
	// Begin is at least two here, so the shifts stay in range
	a_mask_split: assert property ( // RQ7
		{1'b0, mask_begin} > {1'b0, mask_end} + 6'h01
		|-> ~mask == ((32'hffff_ffff >> ({1'b0, mask_end} + 6'h01))
		& (32'hffff_ffff << (6'h20 - {1'b0, mask_begin}))))
		else $error("split mask wrong");

	// Rotator matches the reference for the low five amount bits
	// Higher amount bits must have no effect at all
	a_rot_value: assert property (s_issue_mask |-> // RQ3
		rotated == rot_ref)
		else $error("rotation wrong");

	// Record form raises the condition write next cycle
	a_rec_write: assert property (s_issue_rec |=> cr_wr_o) // RQ8 RQ12
		else $error("condition field not written");

	// Plain form never raises the condition write
	a_cr_record: assert property (s_issue_norec |=> !cr_wr_o) // RQ8
		else $error("condition field written without record");

	// Plain form leaves the held field value alone
	// Software may still read an older recorded result
	a_cr_hold: assert property (s_issue_norec |=> // RQ12
		$stable(condition_field_o))
		else $error("condition field changed without record");

	// Recorded zero and negative bits follow the written word
	a_cr_value: assert property (cr_wr_o |-> // RQ16
		condition_field_o[1] == (wr_data_o == 32'h0000_0000)
		&& condition_field_o[3] == wr_data_o[31])
		else $error("condition field mismatch");

	// Recorded positive bit: sign clear and word not zero
	a_cr_pos: assert property (cr_wr_o |-> // RQ16
		condition_field_o[2] == (!wr_data_o[31]
		&& wr_data_o != 32'h0000_0000))
		else $error("positive flag mismatch");

	// Exactly one of negative, positive and zero is set
	a_cr_onehot: assert property (cr_wr_o |-> // RQ16
		$onehot(condition_field_o[3:1]))
		else $error("condition flags not exclusive");

	// Overflow bit is a copy of the state seen at issue
	// The unit never computes overflow of its own
	a_rec_ovf: assert property (s_issue_rec |=> // RQ16
		condition_field_o[0] == $past(summary_ovf_i))
		else $error("overflow copy wrong");

	// The exception register is never written back
	a_no_xer: assert property (!xer_wr_o) // RQ9
		else $error("exception register written");

	// Echoed exception value is the input one cycle late
	// Any change here would mean the unit altered it
	a_xer_echo: assert property (reset_n_i |=> // RQ13
		xer_o == $past(xer_i))
		else $error("exception value altered");

	// An insert-bit issue writes and is not refused
	a_ins_pulse: assert property (s_issue_ins |=> // RQ10
		wr_en_o && !illegal_o)
		else $error("insert-bit not written");

	// Insert-bit keeps every other destination bit
	a_ins_keep: assert property (s_issue_ins |=> // RQ14
		((wr_data_o ^ $past(dest_data_i))
		& ~(32'h8000_0000 >> $past(rot_count))) == 32'h0000_0000)
		else $error("insert touched other bits");

	// At most one destination bit differs from the old value
	a_ins_onebit: assert property (s_issue_ins |=> // RQ14
		$onehot0(wr_data_o ^ $past(dest_data_i)))
		else $error("insert changed several bits");

	// Inserted bit is the source msb at its rotated place
	// Count n lands msb-first at bit n, word bit 31-n
	a_ins_bit: assert property (s_issue_ins |=> // RQ11
		wr_data_o[5'h1f - $past(rot_count)] == $past(source_data_i[31]))
		else $error("inserted bit wrong");

	// Unknown words are refused: no write, no condition update
	a_bad_refused: assert property (s_issue_bad |=> // RQ1 RQ10
		illegal_o && !wr_en_o && !cr_wr_o)
		else $error("unknown word not refused");

	// Refusal and write never share a cycle
	a_ill_excl: assert property (illegal_o |-> // RQ1
		!wr_en_o && !cr_wr_o)
		else $error("refused word written");

	// No issue, no pulse: every pulse comes one cycle after an issue
	// Back-to-back issues hold the pulse high one cycle per issue
	a_idle_quiet: assert property (s_idle |=> // RQ8
		!wr_en_o && !cr_wr_o && !illegal_o)
		else $error("pulse without issue");

	// Register indices of the issued word reach the next stage
	a_idx_load: assert property (issue_i |=> // RQ2
		source_reg_field_o == $past(instr_i[25:21])
		&& dest_reg_field_o == $past(instr_i[20:16])
		&& amount_reg_field_o == $past(instr_i[15:11]))
		else $error("register index wrong");

	// Primary opcode 23 in the top six bits selects rotate-mask
	a_opc_mask: assert property ( // RQ1 RQ15
		instr_i[31:26] == `RMU_OPC_ROTMASK
		|-> op == rmu_pkg::RMU_OP_ROTMASK)
		else $error("rotate-mask not decoded");

	// Opcode 31 with extended code 537 selects insert-bit
	// A neighbouring extended code must not match
	a_opc_ins: assert property ( // RQ10
		instr_i[31:26] == `RMU_OPC_EXT
		&& instr_i[10:1] == `RMU_XO_INSBIT
		|-> op == rmu_pkg::RMU_OP_INSBIT)
		else $error("insert-bit not decoded");
endmodule

/* File: rtl/rmu_map.svh */
`ifndef RMU_MAP_SVH
`define RMU_MAP_SVH
`define RMU_WORD_W 32
`define RMU_OPC_ROTMASK 6'h17
`define RMU_OPC_EXT 6'h1f
`define RMU_XO_INSBIT 10'h219
`define RMU_CR0_W 4
`endif

/* File: rtl/rmu_pkg.sv */
package rmu_pkg;
	// Operation selected by the decoder
	typedef enum logic [2:0] {
		RMU_OP_NONE = 3'h1,
		RMU_OP_ROTMASK = 3'h2,
		RMU_OP_INSBIT = 3'h4
	} rmu_op_type;
endpackage

/* File: rtl/rmu_mask_gen.sv */
`timescale 1ns/1ps
`include "rmu_map.svh"
// Mask generator, bit 0 is the most significant bit
module rmu_mask_gen (
	input wire logic [4:0] mask_begin_i, // First mask bit
	input wire logic [4:0] mask_end_i, // Last mask bit
	output logic [`RMU_WORD_W-1:0] mask_o // Generated mask
);
	always_comb begin
		for (int i = 0; i < `RMU_WORD_W; i++) begin
			// Index i counts from msb, so word bit is 31-i
			if (mask_begin_i <= mask_end_i) begin
				mask_o[31-i] = (i >= mask_begin_i) && (i <= mask_end_i); // RQ5 RQ15
			end else if ({1'b0, mask_begin_i} == {1'b0, mask_end_i} + 6'h01) begin
				mask_o[31-i] = 1'b1; // RQ6
			end else begin
				// Wrapped: clear end+1 .. begin-1
				mask_o[31-i] = (i <= mask_end_i) || (i >= mask_begin_i); // RQ7
			end
		end
	end
endmodule

/* File: rtl/rmu_rotator.sv */
`timescale 1ns/1ps
`include "rmu_map.svh"
// Left rotator, used by rotate-mask only
module rmu_rotator (
	input wire logic [`RMU_WORD_W-1:0] data_i, // Word to rotate
	input wire logic [4:0] count_i, // Left rotate count
	output logic [`RMU_WORD_W-1:0] data_o // Rotated word
);
	logic [2*`RMU_WORD_W-1:0] dbl; // Doubled word
	always_comb begin
		dbl = {data_i, data_i} << count_i;
		data_o = dbl[2*`RMU_WORD_W-1:`RMU_WORD_W]; // RQ3
	end
endmodule

/* File: bench/rmu_regfile_model.sv */
`timescale 1ns/1ps
// Decode-side register file, operands valid in the issue cycle
module rmu_regfile_model (
	input wire logic sys_clk_i, // Core clock
	input wire logic [31:0] instr_i, // Issued word
	input wire logic wr_en_i, // Write pulse from unit
	input wire logic [4:0] wr_idx_i, // Write index
	input wire logic [31:0] wr_data_i, // Write data
	output logic [31:0] src_o, // Source operand
	output logic [31:0] amt_o, // Amount operand
	output logic [31:0] dst_o // Old destination
);
	logic [31:0] regs [32]; // Preloaded by the bench
	// Field bit n sits at port bit 31-n
	assign src_o = regs[instr_i[25:21]];
	assign amt_o = regs[instr_i[15:11]];
	assign dst_o = regs[instr_i[20:16]];
	// Plain always: the bench also preloads this array
	always @(posedge sys_clk_i) begin
		if (wr_en_i) begin
			regs[wr_idx_i] <= wr_data_i;
		end
	end
endmodule

/* File: bench/test_rotate_mask_unit.sv */
`timescale 1ns/1ps
`include "rmu_map.svh"
module test_rotate_mask_unit;
	logic sys_clk = 0, rst_n = 0, issue = 0, sovf = 0; // Stimulus
	logic [31:0] instr = 0, src, amt, dst, wr_data, xer; // Data paths
	logic [4:0] sidx, aidx, didx; // Index outputs
	logic wr_en, cr_wr, xer_wr, ill; // Pulses
	logic [3:0] cr; // Condition field
	int n_mismatch = 0, checked = 0; // Tallies
	localparam logic [31:0] XV = 32'h0000_a5a5; // Echo probe
	// Clock, 20 ns
	initial begin
		forever #10 sys_clk = ~sys_clk;
	end
	rmu_regfile_model rf_u (.sys_clk_i(sys_clk), .instr_i(instr),
		.wr_en_i(wr_en), .wr_idx_i(didx), .wr_data_i(wr_data),
		.src_o(src), .amt_o(amt), .dst_o(dst));
	rmu_top dut_u (.sys_clk_i(sys_clk), .reset_n_i(rst_n),
		.issue_i(issue), .instr_i(instr), .source_data_i(src),
		.amount_data_i(amt), .dest_data_i(dst), .summary_ovf_i(sovf),
		.xer_i(XV), .source_reg_field_o(sidx), .amount_reg_field_o(aidx),
		.wr_en_o(wr_en), .dest_reg_field_o(didx), .wr_data_o(wr_data),
		.cr_wr_o(cr_wr), .condition_field_o(cr), .xer_wr_o(xer_wr),
		.xer_o(xer), .illegal_o(ill));
	// Compare and tally
	task automatic chk(input string n, input logic [31:0] s, e);
		checked++;
		if (s !== e) begin
			n_mismatch++;
			$display("mismatch %s exp %h seen %h", n, e, s);
		end
	endtask
	// Rotate-mask word, regs 4 source, 6 dest, 5 amount
	function automatic logic [31:0] rm(input logic [4:0] b, e,
		input logic rc);
		return {`RMU_OPC_ROTMASK, 5'h04, 5'h06, 5'h05, b, e, rc};
	endfunction
	function automatic logic [31:0] ib(input logic rc);
		return {`RMU_OPC_EXT, 5'h04, 5'h06, 5'h05, `RMU_XO_INSBIT, rc};
	endfunction
	// One issue, then judge the registered answer
	task automatic op(input logic [31:0] w, s, a, d, input logic so,
		input logic [31:0] e, input logic [3:0] c);
		// Let the last write-back land before loading operands
		repeat (2) @(posedge sys_clk);
		rf_u.regs[4] <= s;
		rf_u.regs[5] <= a;
		rf_u.regs[6] <= d;
		issue <= 1;
		instr <= w;
		sovf <= so;
		@(posedge sys_clk);
		issue <= 0;
		#1;
		chk("wr_en", wr_en, 1);
		chk("wr_data", wr_data, e);
		chk("idx", {sidx, aidx, didx}, 15'h10a6);
		chk("cr_wr", cr_wr, w[0]);
		if (w[0]) chk("cr", cr, c);
		chk("xer_wr", xer_wr, 0);
		chk("xer", xer, XV);
	endtask
	// Worked examples, high amount bits ignored
	task automatic t_mask;
		op(rm(0, 29, 0), 32'h9000_3000, 32'hffff_ffe2, 0, 0,
			32'h4000_c000, 0);
		op(rm(0, 29, 1), 32'hb004_3000, 2, 0, 0, 32'hc010_c000, 4'h8);
		$display("test mask done");
	endtask
	// Full, split and single-bit masks
	task automatic t_wrap;
		op(rm(5, 4, 1), 32'h1234_5678, 32'hffff_ffe0, 0, 1,
			32'h1234_5678, 4'h5);
		op(rm(30, 1, 1), 32'hffff_ffff, 0, 0, 1, 32'hc000_0003, 4'h9);
		op(rm(31, 31, 1), 32'h0000_0001, 0, 0, 0, 1, 4'h4);
		$display("test wrap done");
	endtask
	// Insert-bit at both ends and mid word
	task automatic t_ins;
		op(ib(0), 0, 4, 32'hffff_ffff, 0, 32'hf7ff_ffff, 0);
		op(ib(1), 32'hb004_3000, 4, 0, 0, 32'h0800_0000, 4'h4);
		op(ib(1), 32'h8000_0000, 0, 0, 1, 32'h8000_0000, 4'h9);
		op(ib(1), 32'h7fff_ffff, 31, 0, 0, 0, 4'h2);
		$display("test insert done");
	endtask
	// Wrong extended code is refused
	task automatic t_bad;
		@(posedge sys_clk);
		issue <= 1;
		instr <= {`RMU_OPC_EXT, 15'h0, 10'h218, 1'b1};
		@(posedge sys_clk);
		issue <= 0;
		#1;
		chk("illegal", {ill, wr_en, cr_wr}, 3'h4);
		$display("test illegal done");
	endtask
	task automatic summarize;
		$display("checked %0d n_mismatch %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// Main sequence after a 16-cycle reset
	initial begin
		repeat (16) @(posedge sys_clk);
		rst_n <= 1;
		t_mask;
		t_wrap;
		t_ins;
		t_bad;
		summarize;
	end
	// Watchdog, far beyond the few dozen cycles needed
	initial begin
		#50us;
		n_mismatch++;
		summarize;
	end
endmodule
